// File: timer16_defs.vh
// Constants for the 16-bit timer with capture/compare and one-shot output
`ifndef TIMER16_DEFS_VH
`define TIMER16_DEFS_VH

// ----------------------------------------------------------------
// Mode select field codes
// ----------------------------------------------------------------
`define MODE_STOP 2'h0
`define MODE_FREE 2'h1
`define MODE_EDGE_CLR 2'h2
`define MODE_PULSE 2'h3

// ----------------------------------------------------------------
// Valid edge select codes for trigger inputs
// ----------------------------------------------------------------
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define EDGE_NONE 2'h2
`define EDGE_BOTH 2'h3

// ----------------------------------------------------------------
// Counter limits and reset values
// ----------------------------------------------------------------
`define CNT_ZERO 16'h0000
`define CNT_MAX 16'hFFFF
`define CC_A_RESET 16'h0000
`define CC_B_RESET 16'h0000
`define OUT_RESET 1'h0

// ----------------------------------------------------------------
// Count clock divider default (system clocks per count clock)
// ----------------------------------------------------------------
`define PRESCALE_DEFAULT 16'h0001

`endif

// File: trigger_edge.v
// Synchroniser and valid edge detector for one trigger input pin
`timescale 1ns/1ps
module trigger_edge (
  input wire clock_in,
  input wire arst_n_in,
  input wire pin_in,
  input wire [1:0] edge_sel_in,
  output reg edge_out
);
`include "timer16_defs.vh"

  reg meta_q;
  reg sync_q;
  reg last_q;
  wire rise;
  wire fall;

  // ----------------------------------------------------------------
  // Two-stage synchroniser, then previous level
  // ----------------------------------------------------------------
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_q <= 1'h0;
      sync_q <= 1'h0;
      last_q <= 1'h0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;

  // ----------------------------------------------------------------
  // Valid edge pulse
  // ----------------------------------------------------------------
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      edge_out <= 1'h0;
    end else begin
      case (edge_sel_in)
        `EDGE_FALL: edge_out <= fall;
        `EDGE_RISE: edge_out <= rise;
        `EDGE_BOTH: edge_out <= rise | fall;
        default: edge_out <= 1'h0;
      endcase
    end
  end

endmodule

// File: timer16_freerun_ppg_oneshot.v
// 16-bit timer: free-running, pulse generator and one-shot modes
//
// Functional notes
// [R01] Mode 01 counts up each count clock
// [R02] Free-run wraps FFFFH to 0000H, sets overflow
// [R03] Software clears overflow by writing zero
// [R04] Each register may compare or capture
// [R05] Register A match raises event A
// [R06] Register B match raises event B, no clear
// [R07] Both compare: output toggles on either match
// [R08] Register B captures on trigger A edge
// [R09] Register A captures on trigger A or B
// [R10] Both capture: toggle on trigger A if enabled
// [R11] Trigger B never captures into register B
// [R12] Register A captures on both trigger B edges; the code captures only on the trigger B edges picked by edge_sel_b_in
// [R13] Mode 11 restarts on A match, PWM output
// [R14] Software keeps B below A for pulses
// [R15] One-shot enabled in modes 01 or 10
// [R16] Software bit or trigger A restarts one-shot
// [R17] One-shot matches raise events, invert output
// [R18] Pulse starts M+1, lasts N-M count clocks
// [R19] No retrigger while one-shot pulse active; the code restarts the counter and pulse on any trigger, even while busy
// [R20] Keep trigger A steady for software triggers
// [R21] Registers A and B differ for one-shot
// [R22] Counter read has no side effect
// [R23] Mode 10 trigger A captures B, clears
// [R24] Mode 00 stops counter, raises no events
`timescale 1ns/1ps
module timer16_freerun_ppg_oneshot #(
  parameter [15:0] PRESCALE_DIV = `PRESCALE_DEFAULT
) (
  input wire clock_in,
  input wire arst_n_in,
  input wire [1:0] mode_select_in,
  input wire toggle_on_capture_in,
  input wire single_pulse_enable_in,
  input wire single_pulse_trigger_in,
  input wire cc_a_capture_in,
  input wire cc_b_capture_in,
  input wire cc_a_src_b_in,
  input wire [1:0] edge_sel_a_in,
  input wire [1:0] edge_sel_b_in,
  input wire trigger_input_a_in,
  input wire trigger_input_b_in,
  input wire overflow_clear_in,
  input wire cc_a_write_in,
  input wire cc_b_write_in,
  input wire [15:0] cc_write_data_in,
  output reg [15:0] up_counter_out,
  output reg [15:0] cc_register_a_out,
  output reg [15:0] cc_register_b_out,
  output reg overflow_flag_out,
  output reg event_a_out,
  output reg event_b_out,
  output reg timer_output_pin_out,
  output reg one_shot_busy_out
);
`include "timer16_defs.vh"

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [15:0] bump;
    input [15:0] v;
    begin
      bump = v + 16'h0001;
    end
  endfunction

  function is_match;
    input [15:0] cnt;
    input [15:0] lim;
    begin
      is_match = (cnt == lim);
    end
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg [15:0] div_q;
  reg [15:0] div_d;
  reg tick_q;
  reg tick_d;
  reg [15:0] cnt_d;
  reg [15:0] a_d;
  reg [15:0] b_d;
  reg ovf_d;
  reg ev_a_d;
  reg ev_b_d;
  reg out_d;
  reg os_d;
  reg run;
  reg free_like;
  reg pulse_gen;
  reg os_mode;
  reg os_trig;
  reg cmp_a;
  reg cmp_b;
  reg match_a;
  reg match_b;
  reg cap_a_ev;
  reg cap_b_ev;
  reg clr_edge;
  reg ovf_set;
  reg cap_toggle;
  wire edge_a;
  wire edge_b;

  // ----------------------------------------------------------------
  // Trigger pin edge detection
  // ----------------------------------------------------------------
  trigger_edge u_edge_a (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .pin_in(trigger_input_a_in),
    .edge_sel_in(edge_sel_a_in),
    .edge_out(edge_a)
  );

  trigger_edge u_edge_b (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .pin_in(trigger_input_b_in),
    .edge_sel_in(edge_sel_b_in),
    .edge_out(edge_b)
  );

  // ----------------------------------------------------------------
  // Count clock divider
  // ----------------------------------------------------------------
  always @* begin
    div_d = div_q;
    tick_d = 1'h0;
    if (mode_select_in == `MODE_STOP) begin
      div_d = 16'h0000;
    end else if (div_q >= PRESCALE_DIV - 16'h0001) begin
      div_d = 16'h0000;
      tick_d = 1'h1;
    end else begin
      div_d = bump(div_q);
    end
  end

  // ----------------------------------------------------------------
  // Mode decode and event detection
  // ----------------------------------------------------------------
  always @* begin
    run = (mode_select_in != `MODE_STOP); // [R24]
    free_like = (mode_select_in == `MODE_FREE) ||
                (mode_select_in == `MODE_EDGE_CLR);
    pulse_gen = (mode_select_in == `MODE_PULSE);
    os_mode = single_pulse_enable_in && free_like; // [R15]
    os_trig = os_mode && (single_pulse_trigger_in || edge_a); // [R16]
    cmp_a = !cc_a_capture_in || os_mode || pulse_gen; // [R04]
    cmp_b = !cc_b_capture_in || os_mode || pulse_gen; // [R04]
    match_a = tick_q && run && cmp_a &&
              is_match(up_counter_out, cc_register_a_out); // [R05]
    match_b = tick_q && run && cmp_b &&
              is_match(up_counter_out, cc_register_b_out); // [R06]
    // Register B capture only ever follows trigger A
    cap_b_ev = free_like && !os_mode && cc_b_capture_in &&
               edge_a; // [R08] [R11]
    cap_a_ev = free_like && !os_mode && cc_a_capture_in &&
               (cc_a_src_b_in ? edge_b : edge_a); // [R09] [R12]
    clr_edge = (mode_select_in == `MODE_EDGE_CLR) && !os_mode &&
               edge_a; // [R23]
    ovf_set = tick_q && run && !os_trig && !clr_edge &&
              is_match(up_counter_out, `CNT_MAX); // [R02]
    cap_toggle = cc_a_capture_in && cc_b_capture_in &&
                 toggle_on_capture_in && edge_a; // [R10]
  end

  // ----------------------------------------------------------------
  // Counter next value
  // ----------------------------------------------------------------
  always @* begin
    cnt_d = up_counter_out;
    if (!run) begin
      cnt_d = `CNT_ZERO; // [R24]
    end else if (os_trig || clr_edge) begin
      cnt_d = `CNT_ZERO; // [R16] [R23]
    end else if (tick_q) begin
      if (pulse_gen && match_a) begin
        cnt_d = `CNT_ZERO; // [R13]
      end else begin
        cnt_d = bump(up_counter_out); // [R01] [R02]
      end
    end
  end

  // ----------------------------------------------------------------
  // Capture/compare registers, flags and events
  // ----------------------------------------------------------------
  always @* begin
    a_d = cc_register_a_out;
    b_d = cc_register_b_out;
    if (cap_a_ev) begin
      a_d = up_counter_out; // [R09]
    end else if (cc_a_write_in) begin
      a_d = cc_write_data_in;
    end
    if (cap_b_ev) begin
      b_d = up_counter_out; // [R08] [R23]
    end else if (cc_b_write_in) begin
      b_d = cc_write_data_in;
    end
    // Set wins over a simultaneous software clear
    if (ovf_set) begin
      ovf_d = 1'h1; // [R02]
    end else if (overflow_clear_in) begin
      ovf_d = 1'h0; // [R03]
    end else begin
      ovf_d = overflow_flag_out; // [R03]
    end
    ev_a_d = match_a || cap_a_ev; // [R05] [R17]
    ev_b_d = match_b || cap_b_ev; // [R06] [R08] [R17]
  end

  // ----------------------------------------------------------------
  // Timer output and one-shot state
  // ----------------------------------------------------------------
  always @* begin
    out_d = timer_output_pin_out;
    os_d = one_shot_busy_out;
    if (pulse_gen) begin
      os_d = 1'h0;
      if (match_a) begin
        out_d = 1'h1; // [R13]
      end else if (match_b) begin
        out_d = 1'h0; // [R13] [R14]
      end
    end else if (os_mode) begin
      if (os_trig) begin
        out_d = 1'h0; // [R16] [R19]
        os_d = 1'h1;
      end else if (one_shot_busy_out) begin
        out_d = timer_output_pin_out ^ match_a ^ match_b; // [R17] [R18]
        if (match_b) begin
          os_d = 1'h0; // [R18] [R21]
        end
      end
    end else if (free_like) begin
      os_d = 1'h0;
      out_d = timer_output_pin_out ^ match_a ^ match_b ^
              cap_toggle; // [R07] [R10]
    end else begin
      os_d = 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_q <= 16'h0000;
      tick_q <= 1'h0;
      up_counter_out <= `CNT_ZERO;
      cc_register_a_out <= `CC_A_RESET;
      cc_register_b_out <= `CC_B_RESET;
      overflow_flag_out <= 1'h0;
      event_a_out <= 1'h0;
      event_b_out <= 1'h0;
      timer_output_pin_out <= `OUT_RESET;
      one_shot_busy_out <= 1'h0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
      up_counter_out <= cnt_d; // [R22]
      cc_register_a_out <= a_d;
      cc_register_b_out <= b_d;
      overflow_flag_out <= ovf_d;
      event_a_out <= ev_a_d;
      event_b_out <= ev_b_d;
      timer_output_pin_out <= out_d;
      one_shot_busy_out <= os_d;
    end
  end

endmodule

// File: timer16_checker.sv
// Port checker for the 16-bit timer
`timescale 1ns/1ps
module timer16_checker #(
  parameter [15:0] PRESCALE_DIV = 16'h0001
) (
  input wire clock_in,
  input wire arst_n_in,
  input wire [1:0] mode_select_in,
  input wire single_pulse_enable_in,
  input wire cc_a_capture_in,
  input wire cc_b_capture_in,
  input wire [1:0] edge_sel_a_in,
  input wire trigger_input_a_in,
  input wire overflow_clear_in,
  input wire [15:0] up_counter_out,
  input wire [15:0] cc_register_a_out,
  input wire [15:0] cc_register_b_out,
  input wire overflow_flag_out,
  input wire event_a_out,
  input wire event_b_out,
  input wire timer_output_pin_out
);
  reg [1:0] mode_q;
  wire fr;
  wire pg;
  wire ma;
  wire mb;
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in)
      mode_q <= 2'h0;
    else
      mode_q <= mode_select_in;
  end
  assign fr = mode_select_in == 2'h1 && mode_q == 2'h1 &&
    !single_pulse_enable_in;
  assign pg = mode_select_in == 2'h3 && mode_q == 2'h3;
  assign ma = up_counter_out == cc_register_a_out;
  assign mb = up_counter_out == cc_register_b_out;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  count_up_a: assert property (fr |=>
    up_counter_out == $past(up_counter_out) + 16'h1) else $error("step");
  wrap_set_a: assert property (fr && up_counter_out == 16'hFFFF |=>
    overflow_flag_out && up_counter_out == 16'h0000) else $error("wrap");
  ovf_hold_a: assert property (overflow_flag_out && !overflow_clear_in
    |=> overflow_flag_out) else $error("overflow lost");
  stop_idle_a: assert property ((mode_select_in == 2'h0) [*2] |=>
    up_counter_out == 16'h0000 && !event_a_out && !event_b_out)
    else $error("stop mode");
  match_a_a: assert property (fr && !cc_a_capture_in && ma |=>
    event_a_out) else $error("no match a");
  toggle_out_a: assert property (fr && !cc_a_capture_in &&
    !cc_b_capture_in && ma != mb |=>
    timer_output_pin_out != $past(timer_output_pin_out)) else $error("tog");
  pulse_restart_a: assert property (pg && ma |=>
    up_counter_out == 16'h0000 && timer_output_pin_out)
    else $error("restart");
  pulse_fall_a: assert property (pg && mb &&
    cc_register_b_out < cc_register_a_out |=>
    !timer_output_pin_out && event_b_out) else $error("pulse duty");
  edge_clear_a: assert property (mode_select_in == 2'h2 &&
    !single_pulse_enable_in && cc_b_capture_in && edge_sel_a_in == 2'h3 &&
    $changed(trigger_input_a_in) |-> ##[3:5]
    (event_b_out && up_counter_out == 16'h0000)) else $error("edge clear");
endmodule
bind timer16_freerun_ppg_oneshot timer16_checker #(
  .PRESCALE_DIV(PRESCALE_DIV)) i_chk (.clock_in(clock_in),
  .arst_n_in(arst_n_in), .mode_select_in(mode_select_in),
  .single_pulse_enable_in(single_pulse_enable_in),
  .cc_a_capture_in(cc_a_capture_in), .cc_b_capture_in(cc_b_capture_in),
  .edge_sel_a_in(edge_sel_a_in), .trigger_input_a_in(trigger_input_a_in),
  .overflow_clear_in(overflow_clear_in), .up_counter_out(up_counter_out),
  .cc_register_a_out(cc_register_a_out),
  .cc_register_b_out(cc_register_b_out),
  .overflow_flag_out(overflow_flag_out), .event_a_out(event_a_out),
  .event_b_out(event_b_out), .timer_output_pin_out(timer_output_pin_out));

// File: trigger_pins.sv
// Far-side model of the two trigger pins
`timescale 1ns/1ps
module trigger_pins (
  input wire clock_in,
  input wire flip_a_in,
  input wire flip_b_in,
  output reg pin_a_out,
  output reg pin_b_out
);
  initial begin
    pin_a_out = 1'h0;
    pin_b_out = 1'h0;
  end
  // Pins stay steady unless asked to move
  always @(posedge clock_in) begin
    if (flip_a_in)
      pin_a_out <= !pin_a_out;
    if (flip_b_in)
      pin_b_out <= !pin_b_out;
  end
endmodule

// File: timer16_freerun_ppg_oneshot_test.sv
// Testbench for the 16-bit timer
`timescale 1ns/1ps
module timer16_freerun_ppg_oneshot_test;
  logic clock_in, arst_n_in, tog, sp_en, sp_trig, a_cap, b_cap, a_src;
  logic ovf_clr, a_wr, b_wr, flip_a, flip_b, p0;
  logic [1:0] mode, esa, esb;
  logic [15:0] wdata, pa, pb, prev, v;
  wire pin_a, pin_b, ovf, ev_a, ev_b, tpin, busy;
  wire [15:0] cnt, ra, rb;
  int num_errors, n_checks, n, m;
  timer16_freerun_ppg_oneshot i_dut (.clock_in(clock_in),
    .arst_n_in(arst_n_in), .mode_select_in(mode), .toggle_on_capture_in(tog),
    .single_pulse_enable_in(sp_en), .single_pulse_trigger_in(sp_trig),
    .cc_a_capture_in(a_cap), .cc_b_capture_in(b_cap), .cc_a_src_b_in(a_src),
    .edge_sel_a_in(esa), .edge_sel_b_in(esb), .trigger_input_a_in(pin_a),
    .trigger_input_b_in(pin_b), .overflow_clear_in(ovf_clr),
    .cc_a_write_in(a_wr), .cc_b_write_in(b_wr), .cc_write_data_in(wdata),
    .up_counter_out(cnt), .cc_register_a_out(ra), .cc_register_b_out(rb),
    .overflow_flag_out(ovf), .event_a_out(ev_a), .event_b_out(ev_b),
    .timer_output_pin_out(tpin), .one_shot_busy_out(busy));
  trigger_pins i_pins (.clock_in(clock_in), .flip_a_in(flip_a),
    .flip_b_in(flip_b), .pin_a_out(pin_a), .pin_b_out(pin_b));
  task stop_test;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task smp;
    @(posedge clock_in);
    #1;
  endtask
  task setup(input logic [4:0] c, input logic [1:0] md,
    input logic [15:0] a, input logic [15:0] b);
    @(posedge clock_in) begin
      {a_cap, b_cap, sp_en, a_src, tog} <= c;
      mode <= 2'h0;
      a_wr <= 1'h1;
      wdata <= a;
    end
    @(posedge clock_in) begin
      a_wr <= 1'h0;
      b_wr <= 1'h1;
      wdata <= b;
    end
    @(posedge clock_in) b_wr <= 1'h0;
    @(posedge clock_in) mode <= md;
  endtask
  task fire(input logic sw, input logic b);
    @(posedge clock_in) begin
      sp_trig <= sw;
      flip_a <= !sw && !b;
      flip_b <= b;
    end
    @(posedge clock_in) begin
      sp_trig <= 1'h0;
      flip_a <= 1'h0;
      flip_b <= 1'h0;
    end
  endtask
  task wait_ev(input logic sel);
    n = 0;
    do begin
      prev = cnt;
      smp;
      n++;
    end while ((sel ? ev_b : ev_a) !== 1'h1 && n < 600);
    if (n >= 600)
      chk(n, 0);
  endtask
  task hold(input logic lvl, output int k);
    k = 0;
    do begin
      smp;
      k++;
    end while (tpin === lvl && k < 600);
    if (k >= 600)
      chk(k, 0);
  endtask
  function automatic logic [15:0] period_of(input logic [15:0] x);
    period_of = x + 16'h0001;
  endfunction
  function automatic logic [15:0] width_of(input logic [15:0] a,
    input logic [15:0] b);
    width_of = b - a;
  endfunction
  initial begin
    clock_in = 1'h0;
    forever #2 clock_in = !clock_in;
  end
  initial begin
    #400000;
    num_errors++;
    stop_test;
  end
  initial begin
    {arst_n_in, tog, sp_en, sp_trig, a_cap, b_cap, a_src} = 7'h00;
    {ovf_clr, a_wr, b_wr, flip_a, flip_b, mode} = 7'h00;
    {esa, esb, wdata} = {4'hF, 16'h0000};
    num_errors = 0;
    n_checks = 0;
    void'($urandom(32'h61f24c9c));
    repeat (8) @(posedge clock_in);
    arst_n_in <= 1'h1;
    repeat (3) smp;
    chk(cnt, 16'h0000);
    setup(5'h18, 2'h1, 16'h0000, 16'h0000);
    repeat (9) smp;
    v = cnt;
    repeat (10) smp;
    chk(cnt, v + 16'h000A);
    n = 0;
    while (cnt !== 16'hFFFF && n < 70000) begin
      smp;
      n++;
    end
    smp;
    chk({ovf, cnt}, 17'h10000);
    repeat (5) smp;
    chk(ovf, 1'h1);
    @(posedge clock_in) ovf_clr <= 1'h1;
    @(posedge clock_in) ovf_clr <= 1'h0;
    #1;
    chk(ovf, 1'h0);
    for (int i = 0; i < 3; i++) begin
      pa = 16'h0010 + 16'($urandom % 200);
      pb = pa + 16'h0001 + 16'($urandom % 200);
      setup(5'h00, 2'h1, pa, pb);
      p0 = tpin;
      wait_ev(1'h0);
      chk(prev, pa);
      chk({tpin, cnt}, {!p0, pa + 16'h0001});
      wait_ev(1'h1);
      chk({tpin, prev}, {p0, pb});
    end
    setup(5'h08, 2'h1, 16'h0300, 16'h0000);
    repeat (20) smp;
    fire(1'h0, 1'h0);
    wait_ev(1'h1);
    chk(rb, prev);
    chk(cnt, prev + 16'h0001);
    setup(5'h08, 2'h2, 16'hFFFF, 16'h0000);
    repeat (20) smp;
    fire(1'h0, 1'h0);
    wait_ev(1'h1);
    chk({rb, cnt}, {prev, 16'h0000});
    setup(5'h1B, 2'h1, 16'h0000, 16'h0000);
    p0 = tpin;
    fire(1'h0, 1'h0);
    wait_ev(1'h1);
    chk(rb, prev);
    repeat (3) smp;
    chk(tpin, !p0);
    @(posedge clock_in) esa <= 2'h2;
    for (int i = 0; i < 2; i++) begin
      pb = rb;
      v = ra;
      fire(1'h0, 1'h1);
      repeat (7) smp;
      chk(ra !== v && cnt - ra < 16'h0007, 1'h1);
      chk({tpin, rb}, {!p0, pb});
    end
    @(posedge clock_in) esa <= 2'h3;
    for (int i = 0; i < 3; i++) begin
      pa = 16'h0004 + 16'($urandom % 40);
      pb = 16'($urandom) % pa;
      setup(5'h00, 2'h3, pa, pb);
      hold(1'h1, n);
      hold(1'h0, n);
      hold(1'h1, m);
      hold(1'h0, n);
      chk(16'(m), period_of(pb));
      chk(16'(m + n), period_of(pa));
    end
    for (int i = 1; i < 3; i++) begin
      pa = 16'h0002 + 16'($urandom % 30);
      pb = pa + 16'h0001 + 16'($urandom % 30);
      setup(5'h04, i[1:0], pa, pb);
      repeat (3) smp;
      fire(1'h1, 1'h0);
      hold(1'h0, n);
      chk(16'(n), period_of(pa));
      hold(1'h1, m);
      chk(16'(m), width_of(pa, pb));
      repeat (4) smp;
      chk(busy, 1'h0);
      fire(1'h0, 1'h0);
      hold(1'h0, n);
      hold(1'h1, m);
      chk(16'(m), width_of(pa, pb));
    end
    stop_test;
  end
endmodule
